// ---- hw/bdx_unit.sv ----
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "bdx_cfg.svh"
// Summary of operation
// - Protection fault after stack-segment load sets only access flag.
// - Page-split store after stack-segment load discards the pending hit.
// - Software interrupt after stack-segment load clears all match flags and pending.
// - Simultaneous management interrupt drops the pending data hit.
// - Hit on a debug-register access instruction is reported twice when protection is off and no management interrupt coincides.
// - Each breakpoint armed by its local or global enable.
// - Condition 00 means breakpoint on instruction execution.
// - Disabled register normally raises no instruction breakpoint.
// - Faulting fetch may still hit a disabled execution register when any armed.
module bdx_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Core retire stream
    input wire logic retire,
    input wire logic [31:0] acc_addr,
    input wire logic acc_fetch,
    input wire logic acc_data,
    input wire logic fetch_pf,
    input wire logic stack_segment_load,
    input wire logic store_page_split,
    input wire logic soft_int,
    input wire logic dbg_reg_access,
    input wire logic system_mgmt_interrupt,
    // Exception outputs
    output logic debug_exc,
    output logic smm_entry,
    output logic irq
);
    logic [127:0] bp_address_registers_ff;
    logic [31:0] ctrl_ff;
    bdx_pkg::bdx_flags_t breakpoint_match_flags_ff;
    logic debug_access_detected_flag_ff;
    bdx_pkg::bdx_pend_e pend_ff;
    bdx_pkg::bdx_flags_t pend_hits_ff;
    logic replay_ff;
    logic debug_exc_ff;
    logic smm_entry_ff;
    logic ack_ff;
    logic [3:0] hit;
    logic [3:0] local_bp_enables;
    logic [3:0] global_bp_enables;
    logic debug_reg_protect_enable;
    logic prot_fault;
    logic [`BDX_IRQ_W-1:0] irq_evt;
    logic [`BDX_IRQ_W-1:0] irq_stat;
    logic [`BDX_IRQ_W-1:0] irq_en;
    logic wr;
    logic rd;
    logic drop;
    logic report;
    logic ssl_hit;
    logic plain_hit;

    // Write strobe for one register offset
    function automatic logic wr_at(input logic strobe, input logic [7:0] addr, input logic [7:0] off);
        return strobe && addr == off;
    endfunction

    // Slot of a breakpoint address register
    function automatic logic [1:0] slot_of(input logic [7:0] addr);
        return addr[3:2];
    endfunction

    // Stack-segment shadow state
    function automatic logic is_shadow(input bdx_pkg::bdx_pend_e st);
        return st == bdx_pkg::BDX_SHADOW;
    endfunction

    assign local_bp_enables = ctrl_ff[`BDX_CTRL_LOC_LSB +: 4];
    assign global_bp_enables = ctrl_ff[`BDX_CTRL_GLB_LSB +: 4];
    assign debug_reg_protect_enable = ctrl_ff[`BDX_CTRL_PROT_BIT];

    bdx_match bdx_match_inst (
        .addr_vec(bp_address_registers_ff),
        .armed(local_bp_enables | global_bp_enables),
        .cond(ctrl_ff[`BDX_CTRL_COND_LSB +: 8]),
        .acc_addr(acc_addr),
        .acc_fetch(acc_fetch),
        .acc_data(acc_data),
        .fetch_pf(fetch_pf),
        .hit(hit)
    );

    // Bus handshake: one wait cycle per access
    assign wr = avs_write && ack_ff;
    assign rd = avs_read && ack_ff;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
        end else if (ce) begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0;
        end else if (ce && avs_read && !ack_ff) begin
            unique case (avs_address)
                8'h00, 8'h04, 8'h08, 8'h0c:
                    avs_readdata <= bp_address_registers_ff[slot_of(avs_address)*32 +: 32];
                `BDX_OFF_CTRL: avs_readdata <= ctrl_ff;
                `BDX_OFF_STAT: avs_readdata <= {26'h0, pend_ff != bdx_pkg::BDX_IDLE,
                    debug_access_detected_flag_ff, breakpoint_match_flags_ff};
                `BDX_OFF_IRQ_STAT: avs_readdata <= {29'h0, irq_stat};
                `BDX_OFF_IRQ_EN: avs_readdata <= {29'h0, irq_en};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bp_address_registers_ff <= 128'h0;
        end else if (ce && wr && avs_address[7:4] == 4'h0) begin
            bp_address_registers_ff[slot_of(avs_address)*32 +: 32] <= avs_writedata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_ff <= `BDX_CTRL_RST;
        end else if (ce && wr_at(wr, avs_address, `BDX_OFF_CTRL)) begin
            ctrl_ff <= avs_writedata;
        end
    end

    // Fault on protected debug-register access
    assign prot_fault = retire && dbg_reg_access && debug_reg_protect_enable;
    // Data hit of a stack-segment load
    assign ssl_hit = stack_segment_load && acc_data && |hit;
    assign plain_hit = |hit && !(stack_segment_load && acc_data);
    assign drop = retire && is_shadow(pend_ff) && (system_mgmt_interrupt || store_page_split
        || soft_int || prot_fault);
    assign report = retire && is_shadow(pend_ff) && !drop;

    // Pending state for stack-segment loads
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_ff <= bdx_pkg::BDX_IDLE;
        end else if (ce && retire) begin
            unique case (pend_ff)
                bdx_pkg::BDX_IDLE, bdx_pkg::BDX_HELD: begin
                    if (ssl_hit) begin
                        pend_ff <= bdx_pkg::BDX_SHADOW;
                    end else begin
                        pend_ff <= bdx_pkg::BDX_IDLE;
                    end
                end
                bdx_pkg::BDX_SHADOW: begin
                    pend_ff <= bdx_pkg::BDX_IDLE;
                end
            endcase
        end
    end

    // Hits held while pending
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_hits_ff <= 4'h0;
        end else if (ce && retire) begin
            if (!is_shadow(pend_ff) && ssl_hit) begin
                pend_hits_ff <= hit;
            end else begin
                pend_hits_ff <= 4'h0;
            end
        end
    end

    // Per-breakpoint match flags
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            breakpoint_match_flags_ff <= 4'h0;
        end else if (ce) begin
            if (wr_at(wr, avs_address, `BDX_OFF_STAT)) begin
                breakpoint_match_flags_ff <= avs_writedata[3:0];
            end
            // No match flags on protection fault
            if (retire && !prot_fault) begin
                if (is_shadow(pend_ff) && soft_int) begin
                    breakpoint_match_flags_ff <= 4'h0;
                end else if (report) begin
                    breakpoint_match_flags_ff <= breakpoint_match_flags_ff | pend_hits_ff;
                end else if (plain_hit) begin
                    breakpoint_match_flags_ff <= breakpoint_match_flags_ff | hit;
                end
            end
        end
    end

    // Access-detected flag, set wins over a write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            debug_access_detected_flag_ff <= 1'b0;
        end else if (ce) begin
            if (retire && prot_fault) begin
                debug_access_detected_flag_ff <= 1'b1;
            end else if (wr_at(wr, avs_address, `BDX_OFF_STAT)) begin
                debug_access_detected_flag_ff <= avs_writedata[`BDX_STAT_ACC_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            replay_ff <= 1'b0;
        end else if (ce) begin
            replay_ff <= retire && dbg_reg_access && !prot_fault && |hit;
        end
    end

    // Debug exception pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            debug_exc_ff <= 1'b0;
        end else if (ce) begin
            debug_exc_ff <= replay_ff || (retire && (prot_fault || report ||
                (plain_hit && !system_mgmt_interrupt)));
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            smm_entry_ff <= 1'b0;
        end else if (ce) begin
            smm_entry_ff <= retire && system_mgmt_interrupt;
        end
    end
    assign debug_exc = debug_exc_ff;
    assign smm_entry = smm_entry_ff;

    assign irq_evt = {drop, prot_fault, debug_exc_ff};

    bdx_irq bdx_irq_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .evt(irq_evt),
        .clr(wr_at(wr, avs_address, `BDX_OFF_IRQ_CLR) ? avs_writedata[2:0] : 3'h0),
        .en_we(wr_at(wr, avs_address, `BDX_OFF_IRQ_EN)),
        .en_wdata(avs_writedata[2:0]),
        .stat_ff(irq_stat),
        .en_ff(irq_en),
        .irq(irq)
    );
endmodule

// ---- hw/bdx_cfg.svh ----
`ifndef BDX_CFG_SVH
`define BDX_CFG_SVH
// Register offsets, byte addresses
`define BDX_OFF_ADDR0 8'h00
`define BDX_OFF_CTRL 8'h10
`define BDX_OFF_STAT 8'h14
`define BDX_OFF_IRQ_STAT 8'h18
`define BDX_OFF_IRQ_CLR 8'h1c
`define BDX_OFF_IRQ_EN 8'h20
// Control fields
`define BDX_CTRL_LOC_LSB 0
`define BDX_CTRL_GLB_LSB 4
`define BDX_CTRL_COND_LSB 8
`define BDX_CTRL_PROT_BIT 16
// Status fields
`define BDX_STAT_ACC_BIT 4
`define BDX_STAT_PEND_BIT 5
// Condition code for instruction execution
`define BDX_COND_EXEC 2'h0
`define BDX_CTRL_RST 32'h0000_0000
// Interrupt bits
`define BDX_IRQ_EXC 0
`define BDX_IRQ_ACC 1
`define BDX_IRQ_DROP 2
`define BDX_IRQ_W 3
// Page size
`define BDX_PAGE_BITS 12
`endif

// ---- hw/bdx_pkg.sv ----
package bdx_pkg;
    typedef logic [31:0] bdx_word_t;
    typedef logic [3:0] bdx_flags_t;
    typedef enum logic [1:0] {
        BDX_IDLE,
        BDX_SHADOW,
        BDX_HELD
    } bdx_pend_e;
endpackage

// ---- hw/bdx_match.sv ----
`timescale 1ns/10ps
`include "bdx_cfg.svh"
module bdx_match (
    // Breakpoint setup
    input wire logic [127:0] addr_vec,
    input wire logic [3:0] armed,
    input wire logic [7:0] cond,
    // Access
    input wire logic [31:0] acc_addr,
    input wire logic acc_fetch,
    input wire logic acc_data,
    input wire logic fetch_pf,
    // Hits
    output logic [3:0] hit
);
    always_comb begin
        hit = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (addr_vec[i*32 +: 32] == acc_addr) begin
                if (cond[i*2 +: 2] == `BDX_COND_EXEC) begin
                    hit[i] = acc_fetch && (armed[i] || (fetch_pf && (|armed)));
                end else begin
                    hit[i] = acc_data && armed[i];
                end
            end
        end
    end
endmodule

// ---- hw/bdx_irq.sv ----
`timescale 1ns/10ps
`include "bdx_cfg.svh"
module bdx_irq (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Events and software
    input wire logic [`BDX_IRQ_W-1:0] evt,
    input wire logic [`BDX_IRQ_W-1:0] clr,
    input wire logic en_we,
    input wire logic [`BDX_IRQ_W-1:0] en_wdata,
    // State
    output logic [`BDX_IRQ_W-1:0] stat_ff,
    output logic [`BDX_IRQ_W-1:0] en_ff,
    output logic irq
);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_ff <= '0;
        end else if (ce) begin
            stat_ff <= (stat_ff & ~clr) | evt;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_ff <= '0;
        end else if (ce && en_we) begin
            en_ff <= en_wdata;
        end
    end
    assign irq = |(stat_ff & en_ff);
endmodule

// ---- verif/bdx_unit_properties.sv ----
`timescale 1ns/10ps
module bdx_unit_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Core
    input wire logic retire,
    input wire logic dbg_reg_access,
    input wire logic system_mgmt_interrupt,
    input wire logic debug_exc,
    input wire logic smm_entry,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_REQ_WAIT:
        assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered in its first cycle");
    AST_REQ_ANSWER:
        assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered in second cycle");
    AST_UNMAPPED_ZERO:
        assert property (avs_read && !avs_waitrequest && avs_address > 8'h20 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RST_QUIET:
        assert property ($fell(sys_rst) |-> !debug_exc && !smm_entry && !irq)
        else $error("output active after reset");
    AST_MGMT_TAKEN:
        assert property (retire && system_mgmt_interrupt |=> smm_entry)
        else $error("management interrupt not entered");
    AST_MGMT_CAUSE:
        assert property (smm_entry |-> $past(retire && system_mgmt_interrupt))
        else $error("handler entry without cause");
    AST_EXC_CAUSE:
        assert property (debug_exc |-> $past(retire) || $past(retire, 2))
        else $error("debug exception without retire");
    AST_EXC_TWICE:
        assert property (debug_exc && !retire ##1 debug_exc && !retire |=> !debug_exc)
        else $error("debug exception reported thrice");
    COV_MGMT: cover property (retire && system_mgmt_interrupt && !debug_exc);
    COV_REPLAY: cover property (retire && dbg_reg_access ##1 debug_exc ##1 debug_exc);
    COV_IRQ: cover property ($rose(irq));
endmodule

bind bdx_unit bdx_unit_properties bdx_unit_properties_inst (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .retire, .dbg_reg_access, .system_mgmt_interrupt, .debug_exc, .smm_entry, .irq);

// ---- verif/test_bdx_unit.sv ----
`timescale 1ns/10ps
`include "bdx_cfg.svh"
module test_bdx_unit;
    localparam logic [7:0] FETCH = 8'h01, DATA = 8'h02, PF = 8'h04, SSL = 8'h08, DBG = 8'h40, MGMT = 8'h80;
    localparam logic [7:0] FOLLOW [4] = '{8'h01, 8'h11, 8'h21, 8'h42};
    localparam logic [31:0] STATX [4] = '{32'h4, 32'h0, 32'h0, 32'h10};
    logic clk, sys_rst, ce, avs_read, avs_write, retire;
    logic [7:0] avs_address, qv;
    logic [31:0] avs_writedata, avs_readdata, acc_addr, rd;
    logic avs_waitrequest, debug_exc, smm_entry, irq;
    wire logic acc_fetch, acc_data, fetch_pf, stack_segment_load, store_page_split, soft_int;
    wire logic dbg_reg_access, system_mgmt_interrupt;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int ne, ns;
    assign {system_mgmt_interrupt, dbg_reg_access, soft_int, store_page_split} = qv[7:4];
    assign {stack_segment_load, fetch_pf, acc_data, acc_fetch} = qv[3:0];
    bdx_unit bdx_unit_inst (
        .clk(clk), .sys_rst(sys_rst), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .retire(retire), .acc_addr(acc_addr), .acc_fetch(acc_fetch), .acc_data(acc_data), .fetch_pf(fetch_pf),
        .stack_segment_load(stack_segment_load), .store_page_split(store_page_split), .soft_int(soft_int),
        .dbg_reg_access(dbg_reg_access), .system_mgmt_interrupt(system_mgmt_interrupt),
        .debug_exc(debug_exc), .smm_entry(smm_entry), .irq(irq)
    );
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic irqchk(input logic exp);
        repeat (2) @(posedge clk);
        #1;
        chk(irq, exp);
    endtask
    task automatic step(input logic [31:0] a, input logic [7:0] q);
        int k;
        ne = 0;
        ns = 0;
        @(posedge clk);
        retire <= 1;
        acc_addr <= a;
        qv <= q;
        @(posedge clk);
        retire <= 0;
        qv <= 8'h0;
        for (k = 0; k < 3; k++) begin
            #1;
            if (debug_exc === 1'b1) ne++;
            if (smm_entry === 1'b1) ns++;
            @(posedge clk);
        end
    endtask
    task automatic do_reset();
        sys_rst <= 1;
        repeat (5) @(posedge clk);
        sys_rst <= 0;
    endtask
    initial begin
        sys_rst = 1;
        ce = 1;
        retire = 0;
        qv = 0;
        acc_addr = 0;
        avs_read = 0;
        avs_write = 0;
        avs_address = 0;
        avs_writedata = 0;
        do_reset();
        rdc(`BDX_OFF_CTRL, 32'h0);
        rdc(`BDX_OFF_STAT, 32'h0);
        bus(1, 8'h40, 32'hffff_ffff);
        rdc(8'h40, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            do_reset();
            bus(1, `BDX_OFF_ADDR0 + 8'(4 * i), 32'h1000 + 32'(16 * i));
            bus(1, `BDX_OFF_CTRL, 32'h1 << (i + 4 * (i % 2)));
            step(32'h1004 + 32'(16 * i), FETCH);
            chk(ne, 0);
            step(32'h1000 + 32'(16 * i), FETCH);
            chk(ne, 1);
            rdc(`BDX_OFF_STAT, 32'h1 << i);
        end
        $display("test enables done");
        do_reset();
        bus(1, `BDX_OFF_ADDR0, 32'h2000);
        bus(1, `BDX_OFF_ADDR0 + 8'h4, 32'h3000);
        step(32'h2000, FETCH | PF);
        chk(ne, 0);
        bus(1, `BDX_OFF_CTRL, 32'h2);
        step(32'h2000, FETCH);
        chk(ne, 0);
        step(32'h2000, FETCH | PF);
        chk(ne, 1);
        bus(1, `BDX_OFF_ADDR0, 32'h0);
        step(32'h2000, FETCH | PF);
        chk(ne, 0);
        $display("test disabled done");
        for (int k = 0; k < 4; k++) begin
            do_reset();
            bus(1, `BDX_OFF_ADDR0 + 8'h8, 32'h4000);
            bus(1, `BDX_OFF_CTRL, 32'h0001_3004);
            step(32'h4000, DATA | SSL);
            chk(ne, 0);
            rdc(`BDX_OFF_STAT, 32'h20);
            if (k == 2) bus(1, `BDX_OFF_STAT, 32'hb);
            step(k == 3 ? 32'h4000 : 32'h8000, FOLLOW[k]);
            chk(ne, k == 0 || k == 3);
            rdc(`BDX_OFF_STAT, STATX[k]);
            if (k == 1) begin
                rdc(`BDX_OFF_IRQ_STAT, 32'h4);
                irqchk(0);
                bus(1, `BDX_OFF_IRQ_EN, 32'h4);
                irqchk(1);
                bus(1, `BDX_OFF_IRQ_CLR, 32'h4);
                irqchk(0);
                rdc(`BDX_OFF_IRQ_STAT, 32'h0);
            end
        end
        $display("test pending done");
        do_reset();
        bus(1, `BDX_OFF_ADDR0, 32'h5000);
        bus(1, `BDX_OFF_ADDR0 + 8'hc, 32'h6000);
        bus(1, `BDX_OFF_CTRL, 32'h0000_c081);
        step(32'h6000, DATA | MGMT);
        chk(ns, 1);
        chk(ne, 0);
        step(32'h6000, DATA);
        chk(ne, 1);
        step(32'h5000, FETCH | DBG);
        chk(ne, 2);
        $display("test replay done");
        report_and_stop();
    end
endmodule
